// file: src/standby_ctrl.sv
// module standby control: AXI4-Lite register slave and standby outputs
// assumes a single aclk domain; bus master follows AXI4-Lite handshakes
`timescale 1ns/1ps
module standby_ctrl (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic awvalid,
  output logic awready,
  input wire standby_pkg::word_t awaddr,
  input wire logic [2:0] awprot,
  // axi4-lite write data
  input wire logic wvalid,
  output logic wready,
  input wire standby_pkg::word_t wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read address
  input wire logic arvalid,
  output logic arready,
  input wire standby_pkg::word_t araddr,
  input wire logic [2:0] arprot,
  // axi4-lite read data
  output logic rvalid,
  input wire logic rready,
  output standby_pkg::word_t rdata,
  output logic [1:0] rresp,
  // watchdog clock source: high when clocked by the internal oscillator
  input wire logic wd_clk_is_osc,
  // per-module standby levels, high puts the module in standby
  output logic twowire_sleep,
  output logic serial_sleep,
  output logic converter_sleep,
  output logic watchdog_sleep,
  output logic timer_five_sleep,
  output logic rtc_sleep,
  // subactive and subsleep clock select
  output logic [1:0] sub_clk_sel
);
  import standby_pkg::*;

  typedef struct packed {
    logic aw_rdy;
    logic aw_full;
    word_t aw_addr;
    logic w_rdy;
    logic w_full;
    word_t w_data;
    logic w_lane0;
    logic b_valid;
    logic [1:0] b_resp;
    logic ar_rdy;
    logic r_valid;
    word_t r_data;
    logic [1:0] r_resp;
    byte_t standby;
    logic [1:0] sel_pending;
    logic [1:0] sel_active;
  } ctrl_s;

  ctrl_s s_reg;
  ctrl_s s_next;

  standby_if sb ();

  standby_gate gate (
    .aclk(aclk),
    .aresetn(aresetn),
    .wd_clk_is_osc(wd_clk_is_osc),
    .sb(sb.gate)
  );

  assign sb.standby_bits = s_reg.standby;

  // ----------------------------------------------------------------------
  // register access
  // ----------------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    if (awvalid && s_reg.aw_rdy) begin
      s_next.aw_addr = awaddr;
      s_next.aw_full = 1'b1;
      s_next.aw_rdy = 1'b0;
    end
    if (wvalid && s_reg.w_rdy) begin
      s_next.w_data = wdata;
      s_next.w_lane0 = wstrb[0];
      s_next.w_full = 1'b1;
      s_next.w_rdy = 1'b0;
    end
    if (s_reg.aw_full && s_reg.w_full && !s_reg.b_valid) begin
      s_next.aw_full = 1'b0;
      s_next.w_full = 1'b0;
      s_next.b_valid = 1'b1;
      s_next.b_resp = resp_okay;
      unique case (s_reg.aw_addr)
        standby_off: begin
          if (s_reg.w_lane0) begin
            s_next.standby = s_reg.w_data[7:0] & standby_mask;
          end
        end
        sub_clk_off: begin
          // held back until the write has been answered
          if (s_reg.w_lane0) begin
            s_next.sel_pending = s_reg.w_data[1:0];
          end
        end
        status_off: s_next.b_resp = resp_okay;
        default: s_next.b_resp = resp_slverr;
      endcase
    end
    if (s_reg.b_valid && bready) begin
      s_next.b_valid = 1'b0;
      s_next.aw_rdy = 1'b1;
      s_next.w_rdy = 1'b1;
      s_next.sel_active = s_reg.sel_pending;
    end
    if (arvalid && s_reg.ar_rdy) begin
      s_next.ar_rdy = 1'b0;
      s_next.r_valid = 1'b1;
      s_next.r_resp = resp_okay;
      unique case (araddr)
        standby_off: s_next.r_data = {24'h00_0000,
                                      s_reg.standby & standby_mask};
        sub_clk_off: s_next.r_data = {30'h0000_0000, s_reg.sel_active};
        status_off: s_next.r_data = {26'h000_0000, sb.sleep_now};
        default: begin
          s_next.r_data = 32'h0000_0000;
          s_next.r_resp = resp_slverr;
        end
      endcase
    end
    if (s_reg.r_valid && rready) begin
      s_next.r_valid = 1'b0;
      s_next.ar_rdy = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
      s_reg.aw_rdy <= 1'b1;
      s_reg.w_rdy <= 1'b1;
      s_reg.ar_rdy <= 1'b1;
      s_reg.standby <= standby_reset;
      s_reg.sel_pending <= sub_clk_reset;
      s_reg.sel_active <= sub_clk_reset;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign awready = s_reg.aw_rdy;
  assign wready = s_reg.w_rdy;
  assign bvalid = s_reg.b_valid;
  assign bresp = s_reg.b_resp;
  assign arready = s_reg.ar_rdy;
  assign rvalid = s_reg.r_valid;
  assign rdata = s_reg.r_data;
  assign rresp = s_reg.r_resp;
  assign twowire_sleep = sb.sleep_now[sleep_twowire];
  assign serial_sleep = sb.sleep_now[sleep_serial];
  assign converter_sleep = sb.sleep_now[sleep_adc];
  assign watchdog_sleep = sb.sleep_now[sleep_wdog];
  assign timer_five_sleep = sb.sleep_now[sleep_timer];
  assign rtc_sleep = sb.sleep_now[sleep_rtc];
  assign sub_clk_sel = s_reg.sel_active;

  a_reserved_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    rvalid && $past(araddr == standby_off && arvalid && arready) |->
    rdata[7] == 1'b0 && rdata[2] == 1'b0)
    else $error("reserved standby bit read as one");
  a_reserved_held: assert property (@(posedge aclk) disable iff (!aresetn)
    s_reg.standby[7] == 1'b0 && s_reg.standby[2] == 1'b0)
    else $error("reserved standby bit stored");
  a_sel_after_resp: assert property (@(posedge aclk) disable iff (!aresetn)
    sub_clk_sel != $past(sub_clk_sel) |->
    $past(bvalid && bready))
    else $error("clock select changed before write answered");
  a_sel_applied: assert property (@(posedge aclk) disable iff (!aresetn)
    bvalid && bready |=> sub_clk_sel == $past(s_reg.sel_pending))
    else $error("clock select not applied after write");
  a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    s_reg.aw_full && s_reg.w_full && !bvalid |=> bvalid)
    else $error("write not answered");
  a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    arvalid && arready |=> rvalid && !arready)
    else $error("read not answered");
  a_rtc_out: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 rtc_sleep == $past(s_reg.standby[rtc_sleep_bit]))
    else $error("rtc standby output does not follow its bit");
  a_timer_out: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 timer_five_sleep == $past(s_reg.standby[timer_five_sleep_bit]))
    else $error("timer V standby output does not follow its bit");
endmodule

// file: src/standby_pkg.sv
// constants, field layout and reset values of the module standby control
// assumes a 32-bit AXI4-Lite register bus and one system clock
// ----------------------------------------------------------------------
// Operation
// - Reserved bits 7 and 2 of the standby register always read as zero.
// - Bit 6 set to one puts the two-wire serial interface into standby.
// - Bit 5 set to one puts the serial communication module in standby.
// - Bit 4 set to one puts the analog-to-digital converter in standby.
// - Bit 3 set to one puts the watchdog timer in standby.
// - A watchdog clocked from the internal oscillator ignores bit 3.
// - Bit 1 set to one puts timer V into standby.
// - Bit 0 set to one puts the real-time clock into standby.
// - A new subactive clock select takes effect only after its write ends.
// ----------------------------------------------------------------------
package standby_pkg;
  typedef logic [31:0] word_t;
  typedef logic [7:0] byte_t;

  // register byte addresses
  localparam word_t standby_off = 32'h0000_0000;
  localparam word_t sub_clk_off = 32'h0000_0004;
  localparam word_t status_off = 32'h0000_0008;

  // bit positions in module_standby_control_one
  localparam int twowire_if_sleep_bit = 6;
  localparam int serial_if_sleep_bit = 5;
  localparam int converter_sleep_bit = 4;
  localparam int watchdog_sleep_bit = 3;
  localparam int timer_five_sleep_bit = 1;
  localparam int rtc_sleep_bit = 0;
  localparam byte_t standby_mask = 8'h7b;
  localparam byte_t standby_reset = 8'h00;

  // subactive clock select field
  localparam int sub_clock_select_hi = 1;
  localparam int sub_clock_select_lo = 0;
  localparam logic [1:0] sub_clk_reset = 2'h0;

  // index of each module in the sleep vector
  localparam int sleep_rtc = 0;
  localparam int sleep_timer = 1;
  localparam int sleep_wdog = 2;
  localparam int sleep_adc = 3;
  localparam int sleep_serial = 4;
  localparam int sleep_twowire = 5;
  localparam logic [5:0] sleep_reset = 6'h00;

  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
endpackage

// file: src/standby_if.sv
// carries the standby control bits to the gate and its state back
// assumes both ends run on the same aclk
`timescale 1ns/1ps
interface standby_if;
  logic [7:0] standby_bits;
  logic [5:0] sleep_now;
  modport ctrl (output standby_bits, input sleep_now);
  modport gate (input standby_bits, output sleep_now);
endinterface

// file: src/standby_gate.sv
// turns the stored standby bits into per-module standby levels
// assumes the watchdog clock source flag is synchronous to aclk
`timescale 1ns/1ps
module standby_gate (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // watchdog clock source: high when clocked by the internal oscillator
  input wire logic wd_clk_is_osc,
  // control bits in, standby levels out
  standby_if.gate sb
);
  import standby_pkg::*;

  typedef struct packed {
    logic [5:0] sleep;
  } gate_s;

  gate_s s_reg;
  gate_s s_next;

  always_comb begin
    s_next = s_reg;
    s_next.sleep[sleep_twowire] = sb.standby_bits[twowire_if_sleep_bit];
    s_next.sleep[sleep_serial] = sb.standby_bits[serial_if_sleep_bit];
    s_next.sleep[sleep_adc] = sb.standby_bits[converter_sleep_bit];
    // oscillator-clocked watchdog keeps running whatever bit 3 says
    s_next.sleep[sleep_wdog] = sb.standby_bits[watchdog_sleep_bit] &
                               ~wd_clk_is_osc;
    s_next.sleep[sleep_timer] = sb.standby_bits[timer_five_sleep_bit];
    s_next.sleep[sleep_rtc] = sb.standby_bits[rtc_sleep_bit];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg.sleep <= sleep_reset;
    end else begin
      s_reg <= s_next;
    end
  end

  assign sb.sleep_now = s_reg.sleep;

  a_twowire_follow: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 sb.sleep_now[sleep_twowire] ==
    $past(sb.standby_bits[twowire_if_sleep_bit]))
    else $error("two-wire standby does not follow its bit");
  a_serial_follow: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(sb.standby_bits[serial_if_sleep_bit]) |=>
    sb.sleep_now[sleep_serial])
    else $error("serial module not put in standby");
  a_adc_follow: assert property (@(posedge aclk) disable iff (!aresetn)
    sb.standby_bits[converter_sleep_bit] |=> sb.sleep_now[sleep_adc])
    else $error("converter not put in standby");
  a_wdog_sleeps: assert property (@(posedge aclk) disable iff (!aresetn)
    sb.standby_bits[watchdog_sleep_bit] && !wd_clk_is_osc |=>
    sb.sleep_now[sleep_wdog])
    else $error("watchdog not put in standby");
  a_wdog_osc_runs: assert property (@(posedge aclk) disable iff (!aresetn)
    wd_clk_is_osc |=> !sb.sleep_now[sleep_wdog])
    else $error("oscillator-clocked watchdog was stopped");
  a_timer_follow: assert property (@(posedge aclk) disable iff (!aresetn)
    sb.standby_bits[timer_five_sleep_bit] |=>
    sb.sleep_now[sleep_timer])
    else $error("timer V not put in standby");
  a_rtc_wake: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(sb.standby_bits[rtc_sleep_bit]) |=>
    !sb.sleep_now[sleep_rtc])
    else $error("real-time clock did not wake");
  a_reset_awake: assert property (@(posedge aclk)
    !aresetn |=> sb.sleep_now == sleep_reset)
    else $error("modules not awake after reset");
endmodule

// file: tb/tb_top.sv
// self-checking bench for the module standby control register block
// assumes the standby_ctrl top and standby_pkg; the bench drives all ports
`timescale 1ns/1ps
module tb_top;
  import standby_pkg::*;
  // ----------------------------------------------------------------
  // clock, reset and port signals
  // ----------------------------------------------------------------
  logic aclk = 0, aresetn = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, wd_clk_is_osc = 0;
  word_t awaddr = '0, wdata = '0, araddr = '0, rdata;
  logic [3:0] wstrb = 4'h0;
  logic [1:0] bresp, rresp, sub_clk_sel, sel_at_b, r;
  logic [5:0] sleep_vec;
  logic twowire_sleep, serial_sleep, converter_sleep;
  logic watchdog_sleep, timer_five_sleep, rtc_sleep;
  int num_errors = 0, total_checks = 0;
  word_t d;
  assign sleep_vec = {twowire_sleep, serial_sleep, converter_sleep,
                      watchdog_sleep, timer_five_sleep, rtc_sleep};
  standby_ctrl dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid),
    .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .wd_clk_is_osc(wd_clk_is_osc),
    .twowire_sleep(twowire_sleep), .serial_sleep(serial_sleep),
    .converter_sleep(converter_sleep), .watchdog_sleep(watchdog_sleep),
    .timer_five_sleep(timer_five_sleep), .rtc_sleep(rtc_sleep),
    .sub_clk_sel(sub_clk_sel));
  initial begin
    forever #10 aclk = ~aclk;
  end
  // ----------------------------------------------------------------
  // bus tasks and comparison
  // ----------------------------------------------------------------
  task automatic chk(input word_t got, input word_t exp, input string m);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic wr(input word_t a, input word_t v, input logic [3:0] s);
    logic aw_done, w_done, aw_hs, w_hs;
    aw_done = 0;
    w_done = 0;
    @(posedge aclk);
    awvalid <= 1; awaddr <= a; wvalid <= 1; wdata <= v; wstrb <= s;
    bready <= 1;
    while (!(aw_done && w_done)) begin
      // sample the handshake mid-cycle, where ready is settled
      @(negedge aclk);
      aw_hs = awvalid && awready;
      w_hs = wvalid && wready;
      @(posedge aclk);
      if (aw_hs) begin
        aw_done = 1;
        awvalid <= 0;
      end
      if (w_hs) begin
        w_done = 1;
        wvalid <= 0;
      end
    end
    do @(negedge aclk); while (bvalid !== 1'b1);
    sel_at_b = sub_clk_sel;
    r = bresp;
    @(posedge aclk);
    bready <= 0;
  endtask
  task automatic rd(input word_t a, output word_t v);
    @(posedge aclk);
    arvalid <= 1; araddr <= a; rready <= 1;
    do @(negedge aclk); while (arready !== 1'b1);
    @(posedge aclk);
    arvalid <= 0;
    do @(negedge aclk); while (rvalid !== 1'b1);
    v = rdata;
    r = rresp;
    @(posedge aclk);
    rready <= 0;
  endtask
  task automatic settle();
    repeat (2) @(posedge aclk);
    #1;
  endtask
  function automatic logic [5:0] exp_sleep(input byte_t b, input logic o);
    return {b[6], b[5], b[4], b[3] & ~o, b[1], b[0]};
  endfunction
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    settle();
    chk(sleep_vec, 0, "sleep after reset");
    chk(sub_clk_sel, 0, "select after reset");
    rd(standby_off, d);
    chk(d, 0, "standby reg reset");
  endtask
  task automatic t_reserved();
    wr(standby_off, 32'hffff_ffff, 4'hf);
    rd(standby_off, d);
    chk(d, 32'h0000_007b, "reserved bits read");
    chk(sleep_vec, 6'h3f, "all modules asleep");
    wr(standby_off, 32'h0000_0000, 4'hf);
    settle();
    chk(sleep_vec, 0, "clear wakes all");
  endtask
  task automatic t_each_bit();
    int pos[6] = '{0, 1, 3, 4, 5, 6};
    foreach (pos[i]) begin
      wr(standby_off, 32'h1 << pos[i], 4'h1);
      settle();
      chk(sleep_vec, exp_sleep(8'h1 << pos[i], 0), "one bit");
      rd(status_off, d);
      chk(d, exp_sleep(8'h1 << pos[i], 0), "status bit");
    end
  endtask
  task automatic t_osc();
    wd_clk_is_osc <= 1;
    wr(standby_off, 32'h0000_0008, 4'hf);
    settle();
    chk(watchdog_sleep, 0, "osc keeps watchdog on");
    wd_clk_is_osc <= 0;
    settle();
    chk(watchdog_sleep, 1, "watchdog asleep");
    wr(standby_off, 32'h0000_0000, 4'hf);
    settle();
    chk(watchdog_sleep, 0, "watchdog woken");
  endtask
  task automatic t_subclk();
    logic [1:0] old;
    for (int v = 1; v <= 4; v++) begin
      old = sub_clk_sel;
      wr(sub_clk_off, word_t'(v[1:0]), 4'hf);
      chk(sel_at_b, old, "select before completion");
      #1;
      chk(sub_clk_sel, v[1:0], "select after completion");
    end
  endtask
  task automatic t_bad();
    wr(32'h0000_0010, 32'h1, 4'hf);
    chk(r, resp_slverr, "unmapped write resp");
    rd(32'h0000_0010, d);
    chk(d, 32'h0, "unmapped read data");
    chk(r, resp_slverr, "unmapped read resp");
    wr(standby_off, 32'h7b, 4'he);
    settle();
    chk(sleep_vec, 0, "no byte strobe");
  endtask
  task automatic t_midreset();
    wr(standby_off, 32'h7b, 4'h1);
    @(posedge aclk);
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    settle();
    chk(sleep_vec, 0, "reset mid run");
  endtask
  task automatic summarize();
    if (num_errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    t_reset();
    t_reserved();
    t_each_bit();
    t_osc();
    t_subclk();
    t_bad();
    t_midreset();
    summarize();
  end
  initial begin
    repeat (5000) @(posedge aclk);
    num_errors++;
    summarize();
  end
endmodule
